// file: common/hpmir_pkg.sv
// package for the host port mailbox and interrupt routing block
// assumes a 16-bit word bus on both the host port and the cpu side
package hpmir_pkg;
   localparam logic [15:0] HPMIR_BREAK_ADDR     = 16'h0140;
   localparam logic [15:0] HPMIR_ROUTE_ADDR     = 16'h0142;
   localparam logic [15:0] HPMIR_DOORBELL1_ADDR = 16'h0144;
   localparam logic [15:0] HPMIR_DOORBELL2_ADDR = 16'h0148;
   localparam logic [15:0] HPMIR_MAILBOX_ADDR   = 16'hc0c6;

   localparam logic [15:0] HPMIR_BREAK_RST   = 16'h0000;
   localparam logic [15:0] HPMIR_ROUTE_RST   = 16'h1400;
   localparam logic [15:0] HPMIR_MAILBOX_RST = 16'h0000;

   // routing register fields
   localparam int HPMIR_RT_SWAP_LO  = 0;
   localparam int HPMIR_RT_RESET1   = 1;
   localparam int HPMIR_RT_DONE1    = 2;
   localparam int HPMIR_RT_DONE2    = 3;
   localparam int HPMIR_RT_RESUME1  = 6;
   localparam int HPMIR_RT_RESUME2  = 7;
   localparam int HPMIR_RT_SWAP_HI  = 8;
   localparam int HPMIR_RT_RESET2   = 9;
   localparam int HPMIR_RT_FRM1_CPU = 10;
   localparam int HPMIR_RT_FRM1_HST = 11;
   localparam int HPMIR_RT_FRM2_CPU = 12;
   localparam int HPMIR_RT_FRM2_HST = 13;
   localparam int HPMIR_RT_IDENT    = 14;
   localparam int HPMIR_RT_VBUS     = 15;

   // host status port fields
   localparam int HPMIR_ST_MBX_OUT = 0;
   localparam int HPMIR_ST_RESET1  = 1;
   localparam int HPMIR_ST_DONE1   = 2;
   localparam int HPMIR_ST_DONE2   = 3;
   localparam int HPMIR_ST_DB1     = 4;
   localparam int HPMIR_ST_DB2     = 5;
   localparam int HPMIR_ST_RESUME1 = 6;
   localparam int HPMIR_ST_RESUME2 = 7;
   localparam int HPMIR_ST_MBX_IN  = 8;
   localparam int HPMIR_ST_RESET2  = 9;
   localparam int HPMIR_ST_FRM1    = 10;
   localparam int HPMIR_ST_FRM2    = 12;
   localparam int HPMIR_ST_IDENT   = 14;
   localparam int HPMIR_ST_VBUS    = 15;

   // one access request on a 16-bit word bus
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } hpmir_req_t;

   // engine interrupt lines, already gated by their own enables
   typedef struct packed {
      logic vbus;
      logic ident;
      logic frame2;
      logic frame1;
      logic reset2;
      logic resume2;
      logic resume1;
      logic done2;
      logic done1;
      logic reset1;
   } hpmir_eng_irq_t;
endpackage

// file: dv/hpmir_checker.sv
// assertions on the host port mailbox, doorbell and routing block
// assumes one clock domain; sees only the ports of the top module
`timescale 1ns/1ps
module hpmir_checker (
   input  wire logic                      ref_clk_i,
   input  wire logic                      resetn_i,
   input  wire hpmir_pkg::hpmir_req_t     host_req_i,
   input  wire logic [15:0]               host_status_o,
   input  wire logic                      host_irq_out_o,
   input  wire logic                      db1_irq_en_i,
   input  wire hpmir_pkg::hpmir_req_t     cpu_req_i,
   input  wire logic                      cpu_pc_valid_i,
   input  wire logic                      break_irq_o,
   input  wire logic                      mbx_rx_full_en_i,
   input  wire logic                      mbx_tx_empty_en_i,
   input  wire logic                      mbx_rx_full_irq_o,
   input  wire logic                      mbx_tx_empty_irq_o,
   input  wire hpmir_pkg::hpmir_eng_irq_t eng_irq_i,
   input  wire hpmir_pkg::hpmir_eng_irq_t cpu_eng_irq_o
);
   import hpmir_pkg::*;
   logic h_wr_mbx;
   logic h_rd_mbx;
   logic c_wr_mbx;
   logic c_wr_db1;
   logic h_rd_db1;
   logic h_clr_brk;
   assign h_wr_mbx  = host_req_i.wr && host_req_i.addr == HPMIR_MAILBOX_ADDR;
   assign h_rd_mbx  = host_req_i.rd && host_req_i.addr == HPMIR_MAILBOX_ADDR;
   assign c_wr_mbx  = cpu_req_i.wr && cpu_req_i.addr == HPMIR_MAILBOX_ADDR;
   assign c_wr_db1  = cpu_req_i.wr && cpu_req_i.addr == HPMIR_DOORBELL1_ADDR;
   assign h_rd_db1  = host_req_i.rd && host_req_i.addr == HPMIR_DOORBELL1_ADDR;
   assign h_clr_brk = host_req_i.wr && host_req_i.addr == HPMIR_BREAK_ADDR
                      && host_req_i.wdata == 16'h0000;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_route_reset: assert property (
      $rose(resetn_i) |-> cpu_eng_irq_o == eng_irq_i && !host_irq_out_o)
      else $error("routing not at its reset default");
   a_break_rise: assert property ($rose(break_irq_o) |-> $past(cpu_pc_valid_i))
      else $error("break irq without a pc sample");
   a_break_clear: assert property (h_clr_brk |=> !break_irq_o)
      else $error("zero write did not clear break irq");
   a_break_hold: assert property (break_irq_o && !h_clr_brk |=> break_irq_o)
      else $error("break irq dropped on its own");
   a_db_set: assert property (c_wr_db1 |-> ##2 host_status_o[HPMIR_ST_DB1])
      else $error("doorbell flag not shown in status");
   a_db_irq_pin: assert property (c_wr_db1 && db1_irq_en_i ##1 db1_irq_en_i |-> host_irq_out_o)
      else $error("enabled doorbell did not raise host irq");
   a_db_clear: assert property (
      h_rd_db1 && !c_wr_db1 ##1 !c_wr_db1 |=> !host_status_o[HPMIR_ST_DB1])
      else $error("doorbell flag survived host read");
   a_mbx_rx_full: assert property (h_wr_mbx ##1 mbx_rx_full_en_i |-> mbx_rx_full_irq_o)
      else $error("host mailbox write missed rx full");
   a_mbx_tx_empty: assert property (
      h_rd_mbx && !c_wr_mbx ##1 mbx_tx_empty_en_i |-> mbx_tx_empty_irq_o)
      else $error("host mailbox read missed tx empty");
   a_mbx_host_pin: assert property (c_wr_mbx |=> host_irq_out_o)
      else $error("cpu mailbox write did not raise host irq");

   c_mbx_rx: cover property (h_wr_mbx ##1 mbx_rx_full_irq_o);
   c_db_irq: cover property (c_wr_db1 ##1 host_irq_out_o);
   c_break: cover property ($rose(break_irq_o));
endmodule

bind hpmir_top hpmir_checker u_hpmir_checker (
   .ref_clk_i, .resetn_i, .host_req_i, .host_status_o, .host_irq_out_o, .db1_irq_en_i,
   .cpu_req_i, .cpu_pc_valid_i, .break_irq_o, .mbx_rx_full_en_i, .mbx_tx_empty_en_i,
   .mbx_rx_full_irq_o, .mbx_tx_empty_irq_o, .eng_irq_i, .cpu_eng_irq_o
);

// file: dv/hpmir_host_model.sv
// external processor model on the host port: plain memory cycles
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module hpmir_host_model (
   input  wire logic            ref_clk_i,
   input  wire logic [15:0]     rdata_i,
   output hpmir_pkg::hpmir_req_t req_o,
   output logic                 status_rd_o
);
   import hpmir_pkg::*;
   initial begin
      req_o       = '0;
      status_rd_o = 1'b1;
   end
   // released lines show the inverse so stale values never look valid
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge ref_clk_i);
      #1 req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      @(posedge ref_clk_i);
      #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(posedge ref_clk_i);
      #1 d = rdata_i;
      req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
      @(posedge ref_clk_i);
      #1;
   endtask
   // both swap bits always written alike; frame routing bits pass through from v unchanged
   task automatic set_route(input logic [15:0] v, input logic sw);
      wr(HPMIR_ROUTE_ADDR, {v[15:9], sw, v[7:1], sw});
   endtask
endmodule

// file: dv/testbench.sv
// self-checking bench for the host port mailbox and routing block
// assumes host model and cpu tasks are called one at a time
`timescale 1ns/1ps
module testbench;
   import hpmir_pkg::*;
   logic           ref_clk;
   logic           resetn;
   hpmir_req_t     host_req;
   logic           status_rd;
   logic [15:0]    host_rdata;
   logic [15:0]    status;
   logic           host_irq;
   logic           db1_en;
   logic           db2_en;
   hpmir_req_t     cpu_req;
   logic [15:0]    cpu_rdata;
   logic [15:0]    pc;
   logic           pc_valid;
   logic           brk_irq;
   logic           rx_en;
   logic           tx_en;
   logic           rx_irq;
   logic           tx_irq;
   hpmir_eng_irq_t eng_irq;
   hpmir_eng_irq_t cpu_irq;
   logic [15:0]    rd;
   int             err_count;
   int             checked;

   hpmir_top u_hpmir_top (
      .ref_clk_i(ref_clk), .resetn_i(resetn), .host_req_i(host_req),
      .host_rdata_o(host_rdata), .host_status_rd_i(status_rd), .host_status_o(status),
      .host_irq_out_o(host_irq), .db1_irq_en_i(db1_en), .db2_irq_en_i(db2_en),
      .cpu_req_i(cpu_req), .cpu_rdata_o(cpu_rdata), .cpu_pc_i(pc),
      .cpu_pc_valid_i(pc_valid), .break_irq_o(brk_irq), .mbx_rx_full_en_i(rx_en),
      .mbx_tx_empty_en_i(tx_en), .mbx_rx_full_irq_o(rx_irq),
      .mbx_tx_empty_irq_o(tx_irq), .eng_irq_i(eng_irq), .cpu_eng_irq_o(cpu_irq)
   );
   hpmir_host_model u_hpmir_host_model (
      .ref_clk_i(ref_clk), .rdata_i(host_rdata), .req_o(host_req), .status_rd_o(status_rd)
   );

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cpu_wr(input logic [15:0] a, input logic [15:0] d);
      cpu_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge ref_clk);
      #1 cpu_req <= '0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic cpu_rd(input logic [15:0] a, output logic [15:0] d);
      cpu_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(posedge ref_clk);
      #1 d = cpu_rdata;
      cpu_req <= '0;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #8000;
      err_count++;
      complete_run;
   end

   initial begin
      cpu_req  = '0;
      pc       = 16'h0000;
      pc_valid = 1'b0;
      db1_en   = 1'b1;
      db2_en   = 1'b0;
      rx_en    = 1'b1;
      tx_en    = 1'b1;
      eng_irq  = '1;
      resetn   = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 resetn = 1'b1;
      u_hpmir_host_model.rd(HPMIR_ROUTE_ADDR, rd);
      chk(rd, 16'h1400);
      chk({6'h00, cpu_irq}, 16'h03ff);
      chk({15'h0000, host_irq}, 16'h0000);
      u_hpmir_host_model.rd(HPMIR_MAILBOX_ADDR, rd);
      chk(rd, 16'h0000);
      $display("test reset done");
      cpu_wr(HPMIR_BREAK_ADDR, 16'h5555);
      cpu_rd(HPMIR_BREAK_ADDR, rd);
      chk(rd, 16'h0000);
      u_hpmir_host_model.wr(HPMIR_BREAK_ADDR, 16'h0200);
      cpu_rd(HPMIR_BREAK_ADDR, rd);
      chk(rd, 16'h0200);
      for (int i = 0; i < 2; i++) begin
         pc       <= 16'h0201 - 16'(i);
         pc_valid <= 1'b1;
         @(posedge ref_clk);
         #1 pc_valid <= 1'b0;
         @(posedge ref_clk);
         #1 chk({15'h0000, brk_irq}, 16'(i));
      end
      u_hpmir_host_model.wr(HPMIR_BREAK_ADDR, 16'h0000);
      chk({15'h0000, brk_irq}, 16'h0000);
      $display("test breakpoint done");
      u_hpmir_host_model.set_route(16'heece, 1'b0);
      chk({6'h00, cpu_irq}, 16'h0040);
      chk({15'h0000, host_irq}, 16'h0001);
      chk(status, 16'hd6ce);
      cpu_wr(HPMIR_ROUTE_ADDR, 16'h0000);
      cpu_rd(HPMIR_ROUTE_ADDR, rd);
      chk(rd, 16'heece);
      eng_irq = '0;
      @(posedge ref_clk);
      #1 chk({15'h0000, host_irq}, 16'h0000);
      u_hpmir_host_model.set_route(16'h1400, 1'b0);
      $display("test routing done");
      for (int i = 0; i < 2; i++) begin
         cpu_wr(i ? HPMIR_DOORBELL2_ADDR : HPMIR_DOORBELL1_ADDR, 16'h7e81);
         chk(status, 16'h0010 << i);
         chk({15'h0000, host_irq}, 16'(i == 0));
         u_hpmir_host_model.rd(i ? HPMIR_DOORBELL2_ADDR : HPMIR_DOORBELL1_ADDR, rd);
         chk(status, 16'h0000);
         chk({15'h0000, host_irq}, 16'h0000);
      end
      $display("test doorbell done");
      u_hpmir_host_model.wr(HPMIR_MAILBOX_ADDR, 16'ha5c3);
      chk({rx_irq, status[14:0]}, 16'h8100);
      cpu_rd(HPMIR_MAILBOX_ADDR, rd);
      chk({rx_irq, rd[14:0]}, 16'h25c3);
      cpu_wr(HPMIR_MAILBOX_ADDR, 16'h1234);
      chk({host_irq, tx_irq, status[13:0]}, 16'h8001);
      u_hpmir_host_model.rd(HPMIR_MAILBOX_ADDR, rd);
      chk(rd, 16'h1234);
      chk({host_irq, tx_irq, status[13:0]}, 16'h4000);
      $display("test mailbox done");
      u_hpmir_host_model.set_route(16'h1400, 1'b1);
      u_hpmir_host_model.wr(HPMIR_MAILBOX_ADDR, 16'h1234);
      rx_en = 1'b0;
      @(posedge ref_clk);
      #1 chk({15'h0000, rx_irq}, 16'h0000);
      rx_en = 1'b1;
      cpu_rd(HPMIR_MAILBOX_ADDR, rd);
      chk(rd, 16'h3412);
      u_hpmir_host_model.rd(HPMIR_MAILBOX_ADDR, rd);
      chk(rd, 16'h1234);
      tx_en = 1'b0;
      @(posedge ref_clk);
      #1 chk({15'h0000, tx_irq}, 16'h0000);
      tx_en = 1'b1;
      $display("test swap done");
      complete_run;
   end
endmodule

// file: logic/hpmir_flag.sv
// one sticky event flag, set wins over clear
// assumes set and clear are single-cycle strobes in the core clock domain
`timescale 1ns/1ps
module hpmir_flag (
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   logic flag_reg;
   logic flag_next;

   always_comb begin
      flag_next = flag_reg;
      if (clr_i) begin
         flag_next = 1'b0;
      end
      if (set_i) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag_o = flag_reg;
endmodule

// file: logic/hpmir_swap.sv
// byte lane steering between the host data lines and the internal word
// assumes both swap bits are kept equal; only the high one steers
`timescale 1ns/1ps
module hpmir_swap (
   input  wire logic        swap_i,
   input  wire logic [15:0] word_i,
   output logic      [15:0] word_o
);
   always_comb begin
      word_o = swap_i ? {word_i[7:0], word_i[15:8]} : word_i;
   end
endmodule

// file: logic/hpmir_top.sv
// host port mailbox, breakpoint, doorbells and interrupt routing
// assumes host and cpu requests are one-cycle strobes synchronous to ref_clk_i
`timescale 1ns/1ps

// How it works
// - host writes breakpoint word, cpu only reads
// - pc match raises vector 127, zero clears
// - routing word host writable, cpu read only
// - route bit sends irq to host pin
// - routing picks destination, enables stay elsewhere
// - bits 15,14 move vbus and ident irqs
// - bits 9,7,6,3,2,1 move port irqs
// - frame irqs own host/cpu bits, cpu default one
// - swap bits equal, 11 swaps byte lanes
// - cpu doorbell write sets its flag
// - enabled doorbell flag drives host irq pin
// - host doorbell read clears its flag
// - shared mailbox word, reset zero, both sides
// - host mailbox write fires cpu rx full
// - host mailbox read fires cpu tx empty
// - cpu mailbox write raises host pin, host read drops
// - status bits 0,8 mailbox, 4,5 doorbells
// - status read takes no cpu cycle
module hpmir_top (
   input  wire logic                     ref_clk_i,
   input  wire logic                     resetn_i,
   input  wire hpmir_pkg::hpmir_req_t    host_req_i,
   output logic      [15:0]              host_rdata_o,
   input  wire logic                     host_status_rd_i,
   output logic      [15:0]              host_status_o,
   output logic                          host_irq_out_o,
   input  wire logic                     db1_irq_en_i,
   input  wire logic                     db2_irq_en_i,
   input  wire hpmir_pkg::hpmir_req_t    cpu_req_i,
   output logic      [15:0]              cpu_rdata_o,
   input  wire logic [15:0]              cpu_pc_i,
   input  wire logic                     cpu_pc_valid_i,
   output logic                          break_irq_o,
   input  wire logic                     mbx_rx_full_en_i,
   input  wire logic                     mbx_tx_empty_en_i,
   output logic                          mbx_rx_full_irq_o,
   output logic                          mbx_tx_empty_irq_o,
   input  wire hpmir_pkg::hpmir_eng_irq_t eng_irq_i,
   output hpmir_pkg::hpmir_eng_irq_t     cpu_eng_irq_o
);
   import hpmir_pkg::*;

   logic [15:0] break_reg;
   logic [15:0] break_next;
   logic [15:0] route_reg;
   logic [15:0] route_next;
   logic [15:0] mbx_reg;
   logic [15:0] mbx_next;
   logic        brk_hit_reg;
   logic        brk_hit_next;
   logic [15:0] host_rdata_reg;
   logic [15:0] host_rdata_next;
   logic [15:0] cpu_rdata_reg;
   logic [15:0] cpu_rdata_next;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic [15:0] host_wword;
   logic [15:0] host_rword;

   logic h_wr_brk;
   logic h_wr_route;
   logic h_wr_mbx;
   logic h_rd_mbx;
   logic h_rd_db1;
   logic h_rd_db2;
   logic c_wr_mbx;
   logic c_rd_mbx;
   logic c_wr_db1;
   logic c_wr_db2;
   logic db1_flag;
   logic db2_flag;
   logic mbx_out_flag;
   logic mbx_in_flag;
   logic rx_full_flag;
   logic tx_empty_flag;
   logic host_eng_irq;
   logic [15:0] host_eng_status;

   // host data enters and leaves through the byte steering
   hpmir_swap u_swap_in (
      .swap_i (route_reg[HPMIR_RT_SWAP_HI]),
      .word_i (host_req_i.wdata),
      .word_o (host_wword)
   );

   hpmir_swap u_swap_out (
      .swap_i (route_reg[HPMIR_RT_SWAP_HI]),
      .word_i (host_rdata_next),
      .word_o (host_rword)
   );

   // plain memory cycles, no special protocol
   assign h_wr_brk   = host_req_i.wr && (host_req_i.addr == HPMIR_BREAK_ADDR);
   assign h_wr_route = host_req_i.wr && (host_req_i.addr == HPMIR_ROUTE_ADDR);
   assign h_wr_mbx   = host_req_i.wr && (host_req_i.addr == HPMIR_MAILBOX_ADDR);
   assign h_rd_mbx   = host_req_i.rd && (host_req_i.addr == HPMIR_MAILBOX_ADDR);
   assign h_rd_db1   = host_req_i.rd && (host_req_i.addr == HPMIR_DOORBELL1_ADDR);
   assign h_rd_db2   = host_req_i.rd && (host_req_i.addr == HPMIR_DOORBELL2_ADDR);
   assign c_wr_mbx   = cpu_req_i.wr && (cpu_req_i.addr == HPMIR_MAILBOX_ADDR);
   assign c_rd_mbx   = cpu_req_i.rd && (cpu_req_i.addr == HPMIR_MAILBOX_ADDR);
   assign c_wr_db1   = cpu_req_i.wr && (cpu_req_i.addr == HPMIR_DOORBELL1_ADDR);
   assign c_wr_db2   = cpu_req_i.wr && (cpu_req_i.addr == HPMIR_DOORBELL2_ADDR);

   // register writes; cpu writes to breakpoint and routing are ignored
   always_comb begin
      break_next = break_reg;
      route_next = route_reg;
      mbx_next   = mbx_reg;
      if (h_wr_brk) begin
         break_next = host_wword;
      end
      if (h_wr_route) begin
         route_next = host_wword;
      end
      // a host write lands last when both sides write together
      if (c_wr_mbx) begin
         mbx_next = cpu_req_i.wdata;
      end
      if (h_wr_mbx) begin
         mbx_next = host_wword;
      end
   end

   // breakpoint hit holds until a zero is written
   always_comb begin
      brk_hit_next = brk_hit_reg;
      if (h_wr_brk && (host_wword == 16'h0000)) begin
         brk_hit_next = 1'b0;
      end
      if (cpu_pc_valid_i && (cpu_pc_i == break_reg) && !h_wr_brk) begin
         brk_hit_next = 1'b1;
      end
   end

   // read data, both sides registered
   always_comb begin
      host_rdata_next = 16'h0000;
      unique case (host_req_i.addr)
         HPMIR_BREAK_ADDR:   host_rdata_next = break_reg;
         HPMIR_ROUTE_ADDR:   host_rdata_next = route_reg;
         HPMIR_MAILBOX_ADDR: host_rdata_next = mbx_reg;
         default:            host_rdata_next = 16'h0000;
      endcase
      cpu_rdata_next = 16'h0000;
      unique case (cpu_req_i.addr)
         HPMIR_BREAK_ADDR:   cpu_rdata_next = break_reg;
         HPMIR_ROUTE_ADDR:   cpu_rdata_next = route_reg;
         HPMIR_MAILBOX_ADDR: cpu_rdata_next = mbx_reg;
         default:            cpu_rdata_next = 16'h0000;
      endcase
   end

   // doorbells: cpu write sets, host read of the same word clears
   hpmir_flag u_db1 (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .set_i     (c_wr_db1),
      .clr_i     (h_rd_db1),
      .flag_o    (db1_flag)
   );

   hpmir_flag u_db2 (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .set_i     (c_wr_db2),
      .clr_i     (h_rd_db2),
      .flag_o    (db2_flag)
   );

   // outgoing mailbox: cpu wrote, host has not read yet
   hpmir_flag u_mbx_out (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .set_i     (c_wr_mbx),
      .clr_i     (h_rd_mbx),
      .flag_o    (mbx_out_flag)
   );

   // incoming mailbox doubles as the cpu rx full source
   hpmir_flag u_mbx_in (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .set_i     (h_wr_mbx),
      .clr_i     (c_rd_mbx),
      .flag_o    (mbx_in_flag)
   );

   hpmir_flag u_tx_empty (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .set_i     (h_rd_mbx),
      .clr_i     (c_wr_mbx),
      .flag_o    (tx_empty_flag)
   );

   assign rx_full_flag = mbx_in_flag;

   // routing only steers; eng_irq_i arrives already enabled upstream
   always_comb begin
      host_eng_status = 16'h0000;
      host_eng_status[HPMIR_ST_VBUS]    = eng_irq_i.vbus    && route_reg[HPMIR_RT_VBUS];
      host_eng_status[HPMIR_ST_IDENT]   = eng_irq_i.ident   && route_reg[HPMIR_RT_IDENT];
      host_eng_status[HPMIR_ST_FRM2]    = eng_irq_i.frame2  && route_reg[HPMIR_RT_FRM2_HST];
      host_eng_status[HPMIR_ST_FRM1]    = eng_irq_i.frame1  && route_reg[HPMIR_RT_FRM1_HST];
      host_eng_status[HPMIR_ST_RESET2]  = eng_irq_i.reset2  && route_reg[HPMIR_RT_RESET2];
      host_eng_status[HPMIR_ST_RESUME2] = eng_irq_i.resume2 && route_reg[HPMIR_RT_RESUME2];
      host_eng_status[HPMIR_ST_RESUME1] = eng_irq_i.resume1 && route_reg[HPMIR_RT_RESUME1];
      host_eng_status[HPMIR_ST_DONE2]   = eng_irq_i.done2   && route_reg[HPMIR_RT_DONE2];
      host_eng_status[HPMIR_ST_DONE1]   = eng_irq_i.done1   && route_reg[HPMIR_RT_DONE1];
      host_eng_status[HPMIR_ST_RESET1]  = eng_irq_i.reset1  && route_reg[HPMIR_RT_RESET1];
   end

   assign host_eng_irq = |host_eng_status;

   // cpu keeps whatever is not taken over, except frame irqs, which need their cpu bits
   always_comb begin
      cpu_eng_irq_o.vbus    = eng_irq_i.vbus    && !route_reg[HPMIR_RT_VBUS];
      cpu_eng_irq_o.ident   = eng_irq_i.ident   && !route_reg[HPMIR_RT_IDENT];
      // frame irqs may go both ways; firmware must clear from one side only
      cpu_eng_irq_o.frame2  = eng_irq_i.frame2  && route_reg[HPMIR_RT_FRM2_CPU];
      cpu_eng_irq_o.frame1  = eng_irq_i.frame1  && route_reg[HPMIR_RT_FRM1_CPU];
      cpu_eng_irq_o.reset2  = eng_irq_i.reset2  && !route_reg[HPMIR_RT_RESET2];
      cpu_eng_irq_o.resume2 = eng_irq_i.resume2 && !route_reg[HPMIR_RT_RESUME2];
      cpu_eng_irq_o.resume1 = eng_irq_i.resume1 && !route_reg[HPMIR_RT_RESUME1];
      cpu_eng_irq_o.done2   = eng_irq_i.done2   && !route_reg[HPMIR_RT_DONE2];
      cpu_eng_irq_o.done1   = eng_irq_i.done1   && !route_reg[HPMIR_RT_DONE1];
      cpu_eng_irq_o.reset1  = eng_irq_i.reset1  && !route_reg[HPMIR_RT_RESET1];
   end

   // status word is a side path: no cpu request is made to serve it
   always_comb begin
      status_next = host_eng_status;
      status_next[HPMIR_ST_MBX_OUT] = mbx_out_flag;
      status_next[HPMIR_ST_MBX_IN]  = mbx_in_flag;
      status_next[HPMIR_ST_DB1]     = db1_flag;
      status_next[HPMIR_ST_DB2]     = db2_flag;
   end

   // configuration and mailbox words
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         break_reg <= HPMIR_BREAK_RST;
         route_reg <= HPMIR_ROUTE_RST;
         mbx_reg   <= HPMIR_MAILBOX_RST;
      end else begin
         break_reg <= break_next;
         route_reg <= route_next;
         mbx_reg   <= mbx_next;
      end
   end

   // breakpoint hit request
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         brk_hit_reg <= 1'b0;
      end else begin
         brk_hit_reg <= brk_hit_next;
      end
   end

   // read data is registered so neither bus sees a decode glitch
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         host_rdata_reg <= 16'h0000;
         cpu_rdata_reg  <= 16'h0000;
      end else begin
         host_rdata_reg <= host_rword;
         cpu_rdata_reg  <= cpu_rdata_next;
      end
   end

   // status costs one cycle of lag but never borrows a cpu access
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_reg <= 16'h0000;
      end else begin
         status_reg <= status_next;
      end
   end

   assign host_rdata_o       = host_rdata_reg;
   assign cpu_rdata_o        = cpu_rdata_reg;
   assign host_status_o      = status_reg;
   assign break_irq_o        = brk_hit_reg;
   assign mbx_rx_full_irq_o  = rx_full_flag && mbx_rx_full_en_i;
   assign mbx_tx_empty_irq_o = tx_empty_flag && mbx_tx_empty_en_i;
   assign host_irq_out_o     = mbx_out_flag
                             | (db1_flag && db1_irq_en_i)
                             | (db2_flag && db2_irq_en_i)
                             | host_eng_irq;

   // host_status_rd_i marks a poll only; reading status clears nothing
   logic status_poll_unused;
   assign status_poll_unused = host_status_rd_i;
endmodule
